// file: acb_bank.sv
// Notes on behaviour
// - Writing 1 to distribution sync bit 1 starts output synchronization.
// - Unmasked outputs stall while the bit is 1, restart on 1 to 0.
// - Every reset-functions bit clears itself after being set.
// - Bit 6 of reset functions flushes the loop filter state.
// - Bit 5 of reset functions flushes the pre-filter state.
// - Bit 3 returns automatic synchronization logic to reset.
// - Bit 2 flushes tuning-word history used for holdover.
// - Bit 1 clears every interrupt monitor bit, as all clear bits at once.
// - Bit 0 after watchdog expiry starts a new watchdog cycle.
// - Bit 0 before expiry restarts count from zero, no timeout event.
// - Clear bits mirror monitor layout; a 1 resets that monitor bit.
// - Clear register bits return to 0 by themselves after each write.
// - System clock clear bits 5..0 cover lock and calibration events.
// - Second clear register bits 4..0 cover pin, sync, watchdog, memory.
// - Digital PLL clear bits 7..0 cover loop state and lock events.
// - Fourth clear register bits 4..0 cover history, clamp, slew.
`timescale 1ns/1ps
`default_nettype none
`include "acb_defines.svh"

module acb_bank
   import acb_pkg::*;
#(
   parameter int unsigned WDOG_CYCLES = `ACB_WDOG_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [13:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   output var  logic        dist_stall,
   output var  logic        dist_restart,
   output var  logic        loop_filter_flush,
   output var  logic        prefilter_flush,
   output var  logic        auto_sync_flush,
   output var  logic        tuning_word_history_flush,
   output var  logic [7:0]  irq_clear_sysclock_pll,
   output var  logic [7:0]  irq_clear_sync_watchdog_nvm,
   output var  logic [7:0]  irq_clear_digital_pll,
   output var  logic [7:0]  irq_clear_history_limits,
   output var  logic        wdog_timeout,
   output var  logic        irq
);

   acb_state_t r;
   acb_state_t n;

   // Clear-register bit masks in index order
   localparam logic [3:0][7:0] CLR_MASK = {`ACB_MASK_CLR_HISTORY,
                                           `ACB_MASK_CLR_DPLL,
                                           `ACB_MASK_CLR_SYNC_WD,
                                           `ACB_MASK_CLR_SYSTEM_TIMEBASE_CLOCK};
   localparam logic [31:0] WD_LAST = 32'(WDOG_CYCLES - 1);

   // Word address match at an aligned byte address
   function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
      hit = (a[13:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   // Read data for an address; autoclear registers read as zero
   function automatic logic [31:0] rd_mux(input logic [13:0] a,
                                          input acb_state_t s);
      rd_mux = 32'h0000_0000;
      if (hit(a, `ACB_IDX_DIST_SYNC)) begin
         rd_mux[`ACB_DSYNC_BIT] = s.dsync;
      end
      if (hit(a, `ACB_IDX_EVT_STATUS)) begin
         rd_mux[2:0] = s.sts;
      end
      if (hit(a, `ACB_IDX_EVT_MASK)) begin
         rd_mux[2:0] = s.msk;
      end
      if (hit(a, `ACB_IDX_WDOG_STATUS)) begin
         rd_mux[0] = s.wd_exp;
      end
   endfunction

   logic       wr_go;
   logic [7:0] wd;
   logic       rf_hit;

   // Write commit: request held and waitrequest already low
   assign wr_go  = ce & avs_write & ~avs_read & ~r.wreq & avs_byteenable[0];
   assign wd     = avs_writedata[7:0];
   assign rf_hit = hit(avs_address, `ACB_IDX_RESET_FUNCS);

   // Next-state logic for the whole bank
   always_comb begin
      logic [2:0] ev;
      logic [2:0] w1c;
      logic       wd_clr;
      logic       all_clr;
      n       = r;
      ev      = 3'h0;
      w1c     = 3'h0;
      wd_clr  = 1'b0;
      all_clr = 1'b0;
      if (ce) begin
         // One-cycle strobes fall back to zero
         n.restart = 1'b0;
         n.lf      = 1'b0;
         n.pf      = 1'b0;
         n.asyn    = 1'b0;
         n.twh     = 1'b0;
         n.clr     = '0;
         n.wd_to   = 1'b0;
         // Bus handshake: one wait cycle, then commit
         if ((avs_read | avs_write) && r.wreq) begin
            n.wreq  = 1'b0;
            n.rdata = rd_mux(avs_address, r);
         end else if (!r.wreq) begin
            n.wreq = 1'b1;
         end
         if (wr_go) begin
            if (hit(avs_address, `ACB_IDX_DIST_SYNC)) begin
               n.dsync = wd[`ACB_DSYNC_BIT];
            end
            if (rf_hit) begin
               n.lf    = wd[`ACB_RF_LOOP_FILTER];
               n.pf    = wd[`ACB_RF_PREFILTER];
               n.asyn  = wd[`ACB_RF_AUTO_SYNC];
               n.twh   = wd[`ACB_RF_TW_HISTORY];
               all_clr = wd[`ACB_RF_ALL_IRQ];
               wd_clr  = wd[`ACB_RF_WATCHDOG];
            end
            // Clear strobes follow the monitor layout
            for (int i = 0; i < 4; i++) begin
               if (hit(avs_address, 12'(`ACB_IDX_CLR_SYSTEM_TIMEBASE_CLOCK + i))) begin
                  n.clr[i] = wd & CLR_MASK[i];
               end
            end
            if (hit(avs_address, `ACB_IDX_EVT_STATUS)) begin
               w1c = wd[2:0];
            end
            if (hit(avs_address, `ACB_IDX_EVT_MASK)) begin
               n.msk = wd[2:0];
            end
         end
         if (all_clr) begin
            n.clr = CLR_MASK;
         end
         // Restart pulse on the falling sync bit
         n.restart = r.dsync & ~n.dsync;
         // Watchdog: clear wins over a timeout in the same cycle
         if (wd_clr) begin
            n.wd_cnt = 32'h0000_0000;
            n.wd_exp = 1'b0;
         end else if (!r.wd_exp) begin
            if (r.wd_cnt == WD_LAST) begin
               n.wd_exp = 1'b1;
               n.wd_to  = 1'b1;
               n.wd_cnt = 32'h0000_0000;
            end else begin
               n.wd_cnt = r.wd_cnt + 32'h0000_0001;
            end
         end
         // Sticky events, set wins over write-one clear
         ev[`ACB_EVT_WDOG]      = n.wd_to;
         ev[`ACB_EVT_RESTART]   = n.restart;
         ev[`ACB_EVT_CLEAR_ALL] = all_clr;
         n.sts = (r.sts & ~w1c) | ev;
         n.irq = |(n.sts & n.msk);
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r         <= '0;
         r.wreq    <= 1'b1;
         r.dsync   <= `ACB_DSYNC_RST;
         r.sts     <= `ACB_EVT_RST;
         r.msk     <= `ACB_MSK_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata                = r.rdata;
   assign avs_waitrequest             = r.wreq;
   assign dist_stall                  = r.dsync;
   assign dist_restart                = r.restart;
   assign loop_filter_flush           = r.lf;
   assign prefilter_flush             = r.pf;
   assign auto_sync_flush             = r.asyn;
   assign tuning_word_history_flush   = r.twh;
   assign irq_clear_sysclock_pll      = r.clr[0];
   assign irq_clear_sync_watchdog_nvm = r.clr[1];
   assign irq_clear_digital_pll       = r.clr[2];
   assign irq_clear_history_limits    = r.clr[3];
   assign wdog_timeout                = r.wd_to;
   assign irq                         = r.irq;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_rf_write(int b);
      wr_go && rf_hit && wd[b];
   endsequence

   sequence s_clr_write(int i);
      wr_go && hit(avs_address, 12'(`ACB_IDX_CLR_SYSTEM_TIMEBASE_CLOCK + i));
   endsequence

   sync_bit_a: assert property (wr_go && hit(avs_address, `ACB_IDX_DIST_SYNC)
      |=> dist_stall == $past(avs_writedata[1]))
      else $error("sync bit not stored");
   restart_pulse_a: assert property ($fell(dist_stall) |-> dist_restart)
      else $error("no restart on falling sync");
   strobe_clear_a: assert property (ce && loop_filter_flush |=> !loop_filter_flush)
      else $error("loop filter strobe stuck");
   loop_flush_a: assert property (s_rf_write(`ACB_RF_LOOP_FILTER)
      |=> loop_filter_flush)
      else $error("loop filter not flushed");
   pre_flush_a: assert property (s_rf_write(`ACB_RF_PREFILTER) |=> prefilter_flush)
      else $error("prefilter not flushed");
   sync_flush_a: assert property (s_rf_write(`ACB_RF_AUTO_SYNC) |=> auto_sync_flush)
      else $error("auto sync not reset");
   history_flush_a: assert property (s_rf_write(`ACB_RF_TW_HISTORY)
      |=> tuning_word_history_flush)
      else $error("history not flushed");
   clear_all_a: assert property (s_rf_write(`ACB_RF_ALL_IRQ)
      |=> irq_clear_digital_pll == 8'hFF && irq_clear_sysclock_pll == 8'h3F)
      else $error("clear all incomplete");
   wdog_restart_a: assert property (s_rf_write(`ACB_RF_WATCHDOG)
      |=> r.wd_cnt == 32'h0000_0000 && !r.wd_exp && !wdog_timeout)
      else $error("watchdog not restarted");
   clr_sys_a: assert property (s_clr_write(0)
      |=> irq_clear_sysclock_pll == ($past(wd) & 8'h3F))
      else $error("sysclock clear mismatch");
   clr_hist_a: assert property (s_clr_write(3)
      |=> irq_clear_history_limits == ($past(wd) & 8'h1F))
      else $error("history clear mismatch");
   clr_self_a: assert property (ce && irq_clear_digital_pll != 8'h00
      |=> irq_clear_digital_pll == 8'h00)
      else $error("clear strobe stuck");

   // One wait cycle per access, then waitrequest rises again
   wait_release_a: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   // Restart pulse only follows a falling sync bit
   restart_only_a: assert property ($rose(dist_restart) |-> $fell(dist_stall))
      else $error("restart without falling sync");
   // Remaining reset strobes last one enabled cycle
   strobe_other_a: assert property (ce && (prefilter_flush || auto_sync_flush
      || tuning_word_history_flush) |=> !(prefilter_flush || auto_sync_flush
      || tuning_word_history_flush))
      else $error("reset strobe stuck");
   // A zero written to reset functions starts nothing
   zero_write_a: assert property (wr_go && rf_hit && wd == 8'h00
      |=> !loop_filter_flush && !prefilter_flush && !auto_sync_flush
          && !tuning_word_history_flush && irq_clear_sysclock_pll == 8'h00)
      else $error("zero write acted");
   // Remaining clear registers pass their implemented bits
   clr_wd_a: assert property (s_clr_write(1)
      |=> irq_clear_sync_watchdog_nvm == ($past(wd) & 8'h1F))
      else $error("second clear mismatch");
   clr_dpll_a: assert property (s_clr_write(2) |=> irq_clear_digital_pll == $past(wd))
      else $error("digital PLL clear mismatch");
   clear_all_rest_a: assert property (s_rf_write(`ACB_RF_ALL_IRQ)
      |=> irq_clear_sync_watchdog_nvm == 8'h1F && irq_clear_history_limits == 8'h1F)
      else $error("clear all incomplete");
   // Reserved sysclock clear bits never strobe
   sys_reserved_a: assert property (irq_clear_sysclock_pll[7:6] == 2'b00)
      else $error("reserved sysclock clear bit set");

endmodule
`default_nettype wire

// file: acb_defines.svh
`ifndef ACB_DEFINES_SVH
`define ACB_DEFINES_SVH

// Register indices; byte address is four times the index
`define ACB_IDX_DIST_SYNC      12'h0A02
`define ACB_IDX_RESET_FUNCS    12'h0A03
`define ACB_IDX_CLR_SYSTEM_TIMEBASE_CLOCK     12'h0A04
`define ACB_IDX_CLR_SYNC_WD    12'h0A05
`define ACB_IDX_CLR_DPLL       12'h0A06
`define ACB_IDX_CLR_HISTORY    12'h0A07
`define ACB_IDX_EVT_STATUS     12'h0A10
`define ACB_IDX_EVT_MASK       12'h0A11
`define ACB_IDX_WDOG_STATUS    12'h0A12

// Distribution sync register fields
`define ACB_DSYNC_BIT          1
`define ACB_DSYNC_RST          1'b0

// One-shot reset function bit positions
`define ACB_RF_LOOP_FILTER     6
`define ACB_RF_PREFILTER       5
`define ACB_RF_AUTO_SYNC       3
`define ACB_RF_TW_HISTORY      2
`define ACB_RF_ALL_IRQ         1
`define ACB_RF_WATCHDOG        0

// Implemented bits of each clear register
`define ACB_MASK_CLR_SYSTEM_TIMEBASE_CLOCK    8'h3F
`define ACB_MASK_CLR_SYNC_WD   8'h1F
`define ACB_MASK_CLR_DPLL      8'hFF
`define ACB_MASK_CLR_HISTORY   8'h1F

// Event status bits
`define ACB_EVT_WDOG           0
`define ACB_EVT_RESTART        1
`define ACB_EVT_CLEAR_ALL      2
`define ACB_EVT_RST            3'h0
`define ACB_MSK_RST            3'h0

// Watchdog timeout in cycles
`define ACB_WDOG_CYCLES        100000

`endif

// file: acb_pkg.sv
`default_nettype none
`include "acb_defines.svh"
package acb_pkg;

   // Whole state of the bank
   typedef struct packed {
      logic            wreq;
      logic [31:0]     rdata;
      logic            dsync;
      logic            restart;
      logic            lf;
      logic            pf;
      logic            asyn;
      logic            twh;
      logic [3:0][7:0] clr;
      logic [31:0]     wd_cnt;
      logic            wd_exp;
      logic            wd_to;
      logic [2:0]      sts;
      logic [2:0]      msk;
      logic            irq;
   } acb_state_t;

endpackage
`default_nettype wire

// file: autoclear_control_irq_clear_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "acb_defines.svh"

// Compares a design value with its expectation and counts the outcome
`define TB_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module autoclear_control_irq_clear_bank_test;
   import acb_pkg::*;

   logic        clk;
   logic        rst;
   logic        ce;
   logic [13:0] avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        dist_stall;
   logic        dist_restart;
   logic        lf, pf, asf, twf, wdog_timeout, irq;
   logic [7:0]  c_sys, c_wd, c_dpll, c_hist;
   logic [35:0] strobes;
   logic [31:0] rd_q;
   logic [31:0] allm;
   int          err_total = 0;
   int          samples_checked = 0;
   int          to_cnt = 0;
   int          n;

   // Pulse outputs gathered for one comparison
   assign strobes = {lf, pf, asf, twf, c_sys, c_wd, c_dpll, c_hist};
   assign allm = {`ACB_MASK_CLR_SYSTEM_TIMEBASE_CLOCK, `ACB_MASK_CLR_SYNC_WD, `ACB_MASK_CLR_DPLL,
                  `ACB_MASK_CLR_HISTORY};

   acb_bank #(.WDOG_CYCLES(20)) uut (
      .clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .dist_stall(dist_stall), .dist_restart(dist_restart), .loop_filter_flush(lf),
      .prefilter_flush(pf), .auto_sync_flush(asf), .tuning_word_history_flush(twf),
      .irq_clear_sysclock_pll(c_sys), .irq_clear_sync_watchdog_nvm(c_wd),
      .irq_clear_digital_pll(c_dpll), .irq_clear_history_limits(c_hist),
      .wdog_timeout(wdog_timeout), .irq(irq));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts watchdog expiry pulses
   always @(posedge clk) begin
      if (wdog_timeout === 1'b1) to_cnt++;
   end

   // One bus access: hold the request until waitrequest is seen low
   task automatic bus(input logic [11:0] idx, input logic [7:0] d, input logic be,
                      input logic wr);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= {3'b000, be};
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // Expected pulse pattern in the cycle after commit, idle in the next
   task automatic pulse(input logic [35:0] e);
      @(negedge clk);
      `TB_CHK("strobes", e, strobes)
      @(negedge clk);
      `TB_CHK("strobes idle", 36'h0_0000_0000, strobes)
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      #50000;
      err_total++;
      end_sim();
   end

   initial begin
      rst = 1'b1; ce = 1'b1; avs_address = 14'h0000; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 32'h0000_0000; avs_byteenable = 4'h0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      `TB_CHK("waitrequest in reset", 1'b1, avs_waitrequest)
      `TB_CHK("irq in reset", 1'b0, irq)
      @(posedge clk);
      rst <= 1'b0;
      // Watchdog expires once, then stops counting
      n = 0;
      while (to_cnt == 0 && n < 40) begin @(posedge clk); n++; end
      `TB_CHK("first timeout", 1, to_cnt)
      bus(`ACB_IDX_WDOG_STATUS, 8'h00, 1'b1, 1'b0);
      `TB_CHK("wdog expired", 32'h0000_0001, rd_q)
      // Kicks shorter than the period keep it quiet
      for (int i = 0; i < 4; i++) begin
         bus(`ACB_IDX_RESET_FUNCS, 8'h01, 1'b1, 1'b1);
         repeat (10) @(posedge clk);
      end
      `TB_CHK("no timeout while kicked", 1, to_cnt)
      repeat (40) @(posedge clk);
      `TB_CHK("new timing cycle", 2, to_cnt)
      // Distribution sync: stall while set, restart on 1 to 0
      bus(`ACB_IDX_DIST_SYNC, 8'h00, 1'b1, 1'b0);
      `TB_CHK("dist reset", 32'h0000_0000, rd_q)
      bus(`ACB_IDX_DIST_SYNC, 8'h02, 1'b1, 1'b1);
      @(negedge clk);
      `TB_CHK("dist stall", 1'b1, dist_stall)
      `TB_CHK("no restart", 1'b0, dist_restart)
      bus(`ACB_IDX_DIST_SYNC, 8'h00, 1'b1, 1'b0);
      `TB_CHK("dist readback", 32'h0000_0002, rd_q)
      bus(`ACB_IDX_DIST_SYNC, 8'h00, 1'b1, 1'b1);
      @(negedge clk);
      `TB_CHK("restart pulse", 1'b1, dist_restart)
      `TB_CHK("stall off", 1'b0, dist_stall)
      @(negedge clk);
      `TB_CHK("restart idle", 1'b0, dist_restart)
      bus(`ACB_IDX_EVT_STATUS, 8'h00, 1'b1, 1'b0);
      `TB_CHK("restart event", 32'h0000_0002, rd_q & 32'h0000_0006)
      // Refused writes: byteenable low, unmapped place
      bus(`ACB_IDX_DIST_SYNC, 8'h02, 1'b0, 1'b1);
      bus(`ACB_IDX_DIST_SYNC, 8'h00, 1'b1, 1'b0);
      `TB_CHK("be low ignored", 32'h0000_0000, rd_q)
      bus(12'h0A20, 8'hFF, 1'b1, 1'b1);
      bus(12'h0A20, 8'h00, 1'b1, 1'b0);
      `TB_CHK("unmapped read", 32'h0000_0000, rd_q)
      // Each one-shot flush function (bits 6, 5, 3, 2)
      for (int k = 0; k < 4; k++) begin
         bus(`ACB_IDX_RESET_FUNCS, 8'h40 >> (k + k / 2), 1'b1, 1'b1);
         pulse({4'b1000 >> k, 32'h0000_0000});
      end
      bus(`ACB_IDX_RESET_FUNCS, 8'h00, 1'b1, 1'b1);
      pulse(36'h0_0000_0000);
      bus(`ACB_IDX_RESET_FUNCS, 8'h00, 1'b1, 1'b0);
      `TB_CHK("reset funcs read", 32'h0000_0000, rd_q)
      // Each clear register, reserved bits masked
      for (int k = 0; k < 4; k++) begin
         bus(12'(`ACB_IDX_CLR_SYSTEM_TIMEBASE_CLOCK + k), 8'hFF, 1'b1, 1'b1);
         pulse({4'h0, allm & (32'hFF00_0000 >> (8 * k))});
         bus(12'(`ACB_IDX_CLR_SYSTEM_TIMEBASE_CLOCK + k), 8'h00, 1'b1, 1'b0);
         `TB_CHK("clear reg read", 32'h0000_0000, rd_q)
      end
      // Interrupt: mask, raise by clear-all, clear by writing one
      bus(`ACB_IDX_EVT_STATUS, 8'h06, 1'b1, 1'b1);
      bus(`ACB_IDX_EVT_MASK, 8'h04, 1'b1, 1'b1);
      repeat (2) @(negedge clk);
      `TB_CHK("masked irq", 1'b0, irq)
      bus(`ACB_IDX_RESET_FUNCS, 8'h02, 1'b1, 1'b1);
      pulse({4'h0, allm});
      `TB_CHK("irq raised", 1'b1, irq)
      bus(`ACB_IDX_EVT_STATUS, 8'h00, 1'b1, 1'b0);
      `TB_CHK("clear-all event", 32'h0000_0004, rd_q & 32'h0000_0006)
      bus(`ACB_IDX_EVT_STATUS, 8'h04, 1'b1, 1'b1);
      repeat (2) @(negedge clk);
      `TB_CHK("irq cleared", 1'b0, irq)
      // Clock enable low holds the access and every register
      @(posedge clk);
      ce <= 1'b0;
      fork
         bus(`ACB_IDX_DIST_SYNC, 8'h02, 1'b1, 1'b1);
         begin
            repeat (6) @(negedge clk);
            `TB_CHK("frozen wait", 1'b1, avs_waitrequest)
            `TB_CHK("frozen stall", 1'b0, dist_stall)
            @(posedge clk);
            ce <= 1'b1;
         end
      join
      @(negedge clk);
      `TB_CHK("stall after thaw", 1'b1, dist_stall)
      // Reset in mid-run returns the bank to its idle values
      @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      `TB_CHK("stall in reset", 1'b0, dist_stall)
      `TB_CHK("wait in reset", 1'b1, avs_waitrequest)
      @(posedge clk);
      rst <= 1'b0;
      bus(`ACB_IDX_EVT_STATUS, 8'h00, 1'b1, 1'b0);
      `TB_CHK("status after reset", 32'h0000_0000, rd_q)
      end_sim();
   end
endmodule

`default_nettype wire
